//--- logic/timer_control_top.sv
`timescale 1ns/100ps
`default_nettype none

module timer_control_top (
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  input  wire logic [11:0]                 addr,
  input  wire logic [31:0]                 wdata,
  input  wire logic                        wr_stb,
  input  wire logic                        rd_stb,
  output logic [31:0]                      rdata,
  input  wire logic                        debug_halt,
  input  wire timer_control_pkg::half_in_t half_a_in,
  input  wire timer_control_pkg::half_in_t half_b_in,
  input  wire logic                        rtc_tick,
  output timer_control_pkg::half_out_t     half_a_out,
  output timer_control_pkg::half_out_t     half_b_out,
  output logic                             rtc_run,
  output logic [31:0]                      rtc_count
);

  // ****************************************
  // Register state
  // ****************************************
  logic [31:0] ctl_reg;
  logic [31:0] ctl_next;
  logic [31:0] rtc_reg;
  logic [31:0] rtc_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        rtc_run_reg;

  // ****************************************
  // Address decode
  // ****************************************
  logic        hit_ctl;
  logic        hit_rtc;
  logic        hit_status;
  logic        wr_ctl;
  logic        wr_rtc;
  logic [31:0] status_word;

  assign hit_ctl    = addr == timer_control_pkg::TIMER_CONTROL_OFFSET;
  assign hit_rtc    = addr == timer_control_pkg::RTC_COUNT_OFFSET;
  assign hit_status = addr == timer_control_pkg::RUN_STATUS_OFFSET;
  assign wr_ctl     = wr_stb & hit_ctl;
  assign wr_rtc     = wr_stb & hit_rtc;

  // ****************************************
  // Control register
  // ****************************************
  // reserved bits dropped
  assign ctl_next = wr_ctl ? (wdata & timer_control_pkg::TIMER_CONTROL_MASK) : ctl_reg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctl_reg <= timer_control_pkg::TIMER_CONTROL_RESET;
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  // ****************************************
  // Field extraction
  // ****************************************
  timer_control_pkg::half_ctl_t half_a_ctl;
  timer_control_pkg::half_ctl_t half_b_ctl;
  logic                         rtc_enable;

  assign half_a_ctl.enable         = ctl_reg[timer_control_pkg::HALF_A_ENABLE_BIT];
  assign half_a_ctl.stall_enable   = ctl_reg[timer_control_pkg::HALF_A_STALL_BIT];
  assign half_a_ctl.event_edge     = ctl_reg[timer_control_pkg::HALF_A_EDGE_LSB +: 2];
  assign half_a_ctl.trigger_enable = ctl_reg[timer_control_pkg::HALF_A_TRIGGER_BIT];
  assign half_a_ctl.pwm_invert     = ctl_reg[timer_control_pkg::HALF_A_INVERT_BIT];

  assign half_b_ctl.enable         = ctl_reg[timer_control_pkg::HALF_B_ENABLE_BIT];
  assign half_b_ctl.stall_enable   = ctl_reg[timer_control_pkg::HALF_B_STALL_BIT];
  assign half_b_ctl.event_edge     = ctl_reg[timer_control_pkg::HALF_B_EDGE_LSB +: 2];
  assign half_b_ctl.trigger_enable = ctl_reg[timer_control_pkg::HALF_B_TRIGGER_BIT];
  assign half_b_ctl.pwm_invert     = ctl_reg[timer_control_pkg::HALF_B_INVERT_BIT];

  assign rtc_enable = ctl_reg[timer_control_pkg::RTC_ENABLE_BIT];

  // ****************************************
  // Timer halves
  // ****************************************
  // half A control
  timer_half_ctl half_a_unit (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .ctl        (half_a_ctl),
    .in_sig     (half_a_in),
    .debug_halt (debug_halt),
    .out_reg    (half_a_out)
  );

  timer_half_ctl half_b_unit (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .ctl        (half_b_ctl),
    .in_sig     (half_b_in),
    .debug_halt (debug_halt),
    .out_reg    (half_b_out)
  );

  // ****************************************
  // Real-time clock counter
  // ****************************************
  // count only while enabled
  always_comb begin
    rtc_next = rtc_reg;
    if (wr_rtc) begin
      rtc_next = wdata;
    end else if (rtc_enable && rtc_tick) begin
      rtc_next = rtc_reg + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rtc_reg     <= timer_control_pkg::RTC_COUNT_RESET;
      rtc_run_reg <= 1'b0;
    end else begin
      rtc_reg     <= rtc_next;
      rtc_run_reg <= rtc_enable;
    end
  end

  assign rtc_run   = rtc_run_reg;
  assign rtc_count = rtc_reg;

  // ****************************************
  // Read path
  // ****************************************
  assign status_word = {22'h00_0000, rtc_run_reg,
                        half_b_out.capture_run, half_b_out.count_run,
                        half_a_out.capture_run, half_a_out.count_run,
                        half_b_out.pwm_out, half_a_out.pwm_out,
                        half_b_out.adc_trigger, half_a_out.adc_trigger,
                        debug_halt};

  always_comb begin
    rdata_next = 32'h0000_0000;
    if (rd_stb) begin
      if (hit_ctl) begin
        rdata_next = ctl_reg;
      end else if (hit_rtc) begin
        rdata_next = rtc_reg;
      end else if (hit_status) begin
        rdata_next = status_word;
      end else begin
        rdata_next = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata = rdata_reg;

  // ****************************************
  // Checks
  // ****************************************
  a_ctl_write_store: assert property (@(posedge clk) disable iff (sys_rst)
    (wr_stb && addr == timer_control_pkg::TIMER_CONTROL_OFFSET)
    |=> ctl_reg == ($past(wdata) & timer_control_pkg::TIMER_CONTROL_MASK))
    else $error("control write not stored under mask");

  a_ctl_read_back: assert property (@(posedge clk) disable iff (sys_rst)
    (rd_stb && addr == timer_control_pkg::TIMER_CONTROL_OFFSET && !wr_stb)
    |=> rdata == $past(ctl_reg))
    else $error("control read data wrong");

  a_rtc_hold: assert property (@(posedge clk) disable iff (sys_rst)
    (!rtc_enable && !wr_rtc) |=> $stable(rtc_reg))
    else $error("rtc advanced while disabled");

  a_rtc_advance: assert property (@(posedge clk) disable iff (sys_rst)
    (rtc_enable && rtc_tick && !wr_rtc) |=> rtc_reg == $past(rtc_reg) + 32'h0000_0001)
    else $error("rtc did not advance on tick");

  a_enable_run_a: assert property (@(posedge clk) disable iff (sys_rst)
    (half_a_ctl.enable && !half_a_ctl.stall_enable && !half_a_in.capture_mode)
    |=> half_a_out.count_run)
    else $error("half A not counting when enabled");

  a_disable_idle_b: assert property (@(posedge clk) disable iff (sys_rst)
    !half_b_ctl.enable |=> !half_b_out.count_run && !half_b_out.capture_run)
    else $error("half B runs while disabled");

  a_trigger_reach_b: assert property (@(posedge clk) disable iff (sys_rst)
    (half_b_in.trigger_raw && half_b_ctl.trigger_enable && half_b_ctl.enable)
    |=> half_b_out.adc_trigger)
    else $error("converter trigger from half B lost");

  a_read_one_cycle: assert property (@(posedge clk) disable iff (sys_rst)
    !rd_stb |=> rdata == 32'h0000_0000)
    else $error("read data stands beyond one cycle");

  a_rtc_run_follow: assert property (@(posedge clk) disable iff (sys_rst)
    rtc_enable |=> rtc_run)
    else $error("rtc run flag low while enabled");

  a_rtc_run_stop: assert property (@(posedge clk) disable iff (sys_rst)
    !rtc_enable |=> !rtc_run)
    else $error("rtc run flag high while disabled");

  a_rtc_write_load: assert property (@(posedge clk) disable iff (sys_rst)
    wr_rtc |=> rtc_reg == $past(wdata))
    else $error("rtc write not loaded");

  a_disable_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
    !half_a_ctl.enable |=> !half_a_out.count_run && !half_a_out.capture_run)
    else $error("half A runs while disabled");

  a_enable_run_b: assert property (@(posedge clk) disable iff (sys_rst)
    (half_b_ctl.enable && !half_b_ctl.stall_enable && !half_b_in.capture_mode)
    |=> half_b_out.count_run)
    else $error("half B not counting when enabled");

  a_trigger_reach_a: assert property (@(posedge clk) disable iff (sys_rst)
    (half_a_in.trigger_raw && half_a_ctl.trigger_enable && half_a_ctl.enable)
    |=> half_a_out.adc_trigger)
    else $error("converter trigger from half A lost");

endmodule

`default_nettype wire

//--- logic/timer_control_pkg.sv
// Overview of operation
// - Half enable bit starts counting or capture, chosen by configuration; clear disables half.
// - Half stall enable bit lets the debug halt freeze that half.
// - Two-bit edge field: 00 rising, 01 falling, 11 both, 10 reserved.
// - Half trigger enable bit lets that half drive its trigger output.
// - Timer trigger output serves as converter start signal.
// - Half PWM invert bit inverts that half's PWM output, else unchanged.
// - Bit 4 enables real-time-clock counting; clearing it stops counting.
`default_nettype none

package timer_control_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] TIMER_CONTROL_OFFSET = 12'h00C;
  localparam logic [11:0] RTC_COUNT_OFFSET     = 12'h100;
  localparam logic [11:0] RUN_STATUS_OFFSET    = 12'h104;

  localparam logic [31:0] TIMER_CONTROL_RESET  = 32'h0000_0000;
  localparam logic [31:0] TIMER_CONTROL_MASK   = 32'h0000_6F7F;
  localparam logic [31:0] RTC_COUNT_RESET      = 32'h0000_0000;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int HALF_A_ENABLE_BIT  = 0;
  localparam int HALF_A_STALL_BIT   = 1;
  localparam int HALF_A_EDGE_LSB    = 2;
  localparam int RTC_ENABLE_BIT     = 4;
  localparam int HALF_A_TRIGGER_BIT = 5;
  localparam int HALF_A_INVERT_BIT  = 6;
  localparam int HALF_B_ENABLE_BIT  = 8;
  localparam int HALF_B_STALL_BIT   = 9;
  localparam int HALF_B_EDGE_LSB    = 10;
  localparam int HALF_B_TRIGGER_BIT = 13;
  localparam int HALF_B_INVERT_BIT  = 14;

  // ****************************************
  // Event edge codes
  // ****************************************
  localparam logic [1:0] EDGE_RISING  = 2'h0;
  localparam logic [1:0] EDGE_FALLING = 2'h1;
  localparam logic [1:0] EDGE_RSVD    = 2'h2;
  localparam logic [1:0] EDGE_BOTH    = 2'h3;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic       pwm_invert;
    logic       trigger_enable;
    logic [1:0] event_edge;
    logic       stall_enable;
    logic       enable;
  } half_ctl_t;

  typedef struct packed {
    logic capture_mode;
    logic capture_pin;
    logic pwm_raw;
    logic trigger_raw;
  } half_in_t;

  typedef struct packed {
    logic count_run;
    logic capture_run;
    logic capture_event;
    logic pwm_out;
    logic adc_trigger;
  } half_out_t;

endpackage

`default_nettype wire

//--- logic/timer_half_ctl.sv
`timescale 1ns/100ps
`default_nettype none

module timer_half_ctl (
  input  wire logic                         clk,
  input  wire logic                         sys_rst,
  input  wire timer_control_pkg::half_ctl_t ctl,
  input  wire timer_control_pkg::half_in_t  in_sig,
  input  wire logic                         debug_halt,
  output timer_control_pkg::half_out_t      out_reg
);

  // ****************************************
  // Run and edge decode
  // ****************************************
  logic                         pin_prev_reg;
  logic                         stalled;
  logic                         active;
  logic                         rise;
  logic                         fall;
  logic                         edge_hit;
  timer_control_pkg::half_out_t out_next;

  assign stalled = ctl.stall_enable & debug_halt;
  assign active  = ctl.enable & ~stalled;
  assign rise    = in_sig.capture_pin & ~pin_prev_reg;
  assign fall    = ~in_sig.capture_pin & pin_prev_reg;

  always_comb begin
    case (ctl.event_edge)
      timer_control_pkg::EDGE_RISING:  edge_hit = rise;
      timer_control_pkg::EDGE_FALLING: edge_hit = fall;
      timer_control_pkg::EDGE_BOTH:    edge_hit = rise | fall;
      default:                         edge_hit = 1'b0;
    endcase
  end

  assign out_next.count_run     = active & ~in_sig.capture_mode;
  assign out_next.capture_run   = active & in_sig.capture_mode;
  assign out_next.capture_event = active & in_sig.capture_mode & edge_hit;
  assign out_next.pwm_out       = in_sig.pwm_raw ^ ctl.pwm_invert;
  assign out_next.adc_trigger   = in_sig.trigger_raw & ctl.trigger_enable & ctl.enable;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_prev_reg <= 1'b0;
      out_reg      <= '0;
    end else begin
      pin_prev_reg <= in_sig.capture_pin;
      out_reg      <= out_next;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_pwm_invert_follow: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(sys_rst) |-> out_reg.pwm_out == ($past(in_sig.pwm_raw) ^ $past(ctl.pwm_invert)))
    else $error("pwm output does not follow invert bit");

  a_trigger_gate: assert property (@(posedge clk) disable iff (sys_rst)
    (!ctl.trigger_enable || !ctl.enable) |=> !out_reg.adc_trigger)
    else $error("trigger driven while disabled");

  a_stall_halts: assert property (@(posedge clk) disable iff (sys_rst)
    (ctl.stall_enable && debug_halt) |=> !out_reg.count_run && !out_reg.capture_run)
    else $error("half runs while stalled");

  a_reserved_edge_quiet: assert property (@(posedge clk) disable iff (sys_rst)
    (ctl.event_edge == timer_control_pkg::EDGE_RSVD) |=> !out_reg.capture_event)
    else $error("capture event on reserved edge code");

  a_rising_edge_seen: assert property (@(posedge clk) disable iff (sys_rst)
    (active && in_sig.capture_mode && ctl.event_edge == timer_control_pkg::EDGE_RISING
     && in_sig.capture_pin && !pin_prev_reg) |=> out_reg.capture_event)
    else $error("rising edge missed");

endmodule

`default_nettype wire

//--- sim/dual_timer_control_register_bench.sv
`timescale 1ns/100ps
`default_nettype none

module dual_timer_control_register_bench;

  // ****************************************
  // Signals
  // ****************************************
  logic                            clk;
  logic                            sys_rst;
  logic [11:0]                     addr;
  logic [31:0]                     wdata;
  logic                            wr_stb;
  logic                            rd_stb;
  logic [31:0]                     rdata;
  logic                            debug_halt;
  logic                            rtc_tick;
  logic                            rtc_run;
  logic [31:0]                     rtc_count;
  logic [1:0]                      cm;
  logic [1:0]                      cp;
  logic [1:0]                      pr;
  logic [1:0]                      tr;
  timer_control_pkg::half_in_t     hin [2];
  timer_control_pkg::half_out_t    ho [2];
  int                              err_total;
  int                              num_checks;
  int                              h;
  int                              c;
  int                              sh;

  assign hin[0] = {cm[0], cp[0], pr[0], tr[0]};
  assign hin[1] = {cm[1], cp[1], pr[1], tr[1]};

  timer_control_top dut (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .addr       (addr),
    .wdata      (wdata),
    .wr_stb     (wr_stb),
    .rd_stb     (rd_stb),
    .rdata      (rdata),
    .debug_halt (debug_halt),
    .half_a_in  (hin[0]),
    .half_b_in  (hin[1]),
    .rtc_tick   (rtc_tick),
    .half_a_out (ho[0]),
    .half_b_out (ho[1]),
    .rtc_run    (rtc_run),
    .rtc_count  (rtc_count)
  );

  // ****************************************
  // Clock
  // ****************************************
  initial clk = 1'b0;
  always #20 clk = ~clk;

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    if (err_total == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_stb <= 1'b1;
    addr   <= a;
    wdata  <= d;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    rd_stb <= 1'b1;
    addr   <= a;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    chk(rdata, e);
    cyc(1);
    chk(rdata, 32'h0000_0000);
  endtask

  // ****************************************
  // Watchdog
  // ****************************************
  initial begin
    #2000000;
    err_total++;
    stop_test();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    err_total = 0;
    num_checks = 0;
    sys_rst = 1'b1;
    addr = 12'h000;
    wdata = 32'h0000_0000;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    debug_halt = 1'b0;
    rtc_tick = 1'b0;
    cm = 2'h0;
    cp = 2'h0;
    pr = 2'h0;
    tr = 2'h0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    rd(timer_control_pkg::TIMER_CONTROL_OFFSET, 32'h0000_0000);
    rd(timer_control_pkg::RTC_COUNT_OFFSET, 32'h0000_0000);
    wr(timer_control_pkg::TIMER_CONTROL_OFFSET, 32'hFFFF_FFFF);
    rd(timer_control_pkg::TIMER_CONTROL_OFFSET, 32'h0000_6F7F);
    wr(12'h010, 32'hFFFF_FFFF);
    rd(12'h010, 32'h0000_0000);
    for (h = 0; h < 2; h++) begin
      sh = 8 * h;
      wr(timer_control_pkg::TIMER_CONTROL_OFFSET, 32'h0000_0001 << sh);
      cyc(1);
      chk(ho[h].count_run, 1'b1);
      chk(ho[h].capture_run, 1'b0);
      @(posedge clk);
      cm[h] <= 1'b1;
      debug_halt <= 1'b1;
      cyc(1);
      chk(ho[h].capture_run, 1'b1);
      wr(timer_control_pkg::TIMER_CONTROL_OFFSET, 32'h0000_0003 << sh);
      cyc(1);
      chk(ho[h].capture_run, 1'b0);
      @(posedge clk);
      debug_halt <= 1'b0;
      cyc(1);
      chk(ho[h].capture_run, 1'b1);
      for (c = 0; c < 4; c++) begin
        wr(timer_control_pkg::TIMER_CONTROL_OFFSET, (32'h1 | (c << 2)) << sh);
        @(posedge clk);
        cp[h] <= 1'b1;
        cyc(1);
        chk(ho[h].capture_event, (c == 0) || (c == 3));
        @(posedge clk);
        cp[h] <= 1'b0;
        cyc(1);
        chk(ho[h].capture_event, (c == 1) || (c == 3));
      end
      wr(timer_control_pkg::TIMER_CONTROL_OFFSET, 32'h0000_0021 << sh);
      @(posedge clk);
      cm[h] <= 1'b0;
      tr[h] <= 1'b1;
      pr[h] <= 1'b1;
      cyc(1);
      chk(ho[h].count_run, 1'b1);
      chk(ho[h].adc_trigger, 1'b1);
      chk(ho[h].pwm_out, 1'b1);
      @(posedge clk);
      tr[h] <= 1'b0;
      cyc(1);
      chk(ho[h].adc_trigger, 1'b0);
      wr(timer_control_pkg::TIMER_CONTROL_OFFSET, 32'h0000_0041 << sh);
      @(posedge clk);
      tr[h] <= 1'b1;
      cyc(1);
      chk(ho[h].adc_trigger, 1'b0);
      chk(ho[h].pwm_out, 1'b0);
      @(posedge clk);
      tr[h] <= 1'b0;
      pr[h] <= 1'b0;
      cm[h] <= 1'b0;
      cyc(1);
      chk(ho[h].pwm_out, 1'b1);
      wr(timer_control_pkg::TIMER_CONTROL_OFFSET, 32'h0000_0000);
      cyc(1);
      chk(ho[h], 5'h00);
    end
    wr(timer_control_pkg::TIMER_CONTROL_OFFSET, 32'h0000_0010);
    cyc(1);
    chk(rtc_run, 1'b1);
    @(posedge clk);
    rtc_tick <= 1'b1;
    repeat (3) @(posedge clk);
    rtc_tick <= 1'b0;
    rd(timer_control_pkg::RTC_COUNT_OFFSET, 32'h0000_0003);
    wr(timer_control_pkg::TIMER_CONTROL_OFFSET, 32'h0000_0000);
    @(posedge clk);
    rtc_tick <= 1'b1;
    repeat (2) @(posedge clk);
    rtc_tick <= 1'b0;
    cyc(1);
    chk(rtc_run, 1'b0);
    chk(rtc_count, 32'h0000_0003);
    wr(timer_control_pkg::RTC_COUNT_OFFSET, 32'h0000_00A5);
    rd(timer_control_pkg::RTC_COUNT_OFFSET, 32'h0000_00A5);
    wr(timer_control_pkg::TIMER_CONTROL_OFFSET, 32'h0000_0011);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    chk(ho[0], 5'h00);
    chk(rtc_run, 1'b0);
    chk(rtc_count, 32'h0000_0000);
    rd(timer_control_pkg::TIMER_CONTROL_OFFSET, 32'h0000_0000);
    stop_test();
  end

endmodule

`default_nettype wire
